// ---- shared/port_io_map.svh ----
// Offsets, reset values and field positions of the five-pin port.
// Assumes inclusion by bare name from the package and the design files.
`ifndef PORT_IO_MAP_SVH
`define PORT_IO_MAP_SVH

// Register indices; byte address is four times the index
`define IOP_DIR_INDEX          16'hFFCD
`define IOP_DATA_INDEX         16'hFFCF
`define IOP_INDEX_MSB          17
`define IOP_INDEX_LSB          2
`define IOP_ADDR_WIDTH         18

// Reset values and fixed read values
`define IOP_DIR_RESET_LOW      8'hF0
`define IOP_DIR_RESET_HIGH     8'hE0
`define IOP_DATA_RESET         8'hE0
`define IOP_DIR_READ_VALUE     8'hFF
`define IOP_RESERVED_ONES      3'h7

// Field layout
`define IOP_PIN_COUNT          5
`define IOP_CS_COUNT           4
`define IOP_IRQ_COUNT          4
`define IOP_MODE_WIDTH         3

// Mode boundaries
`define IOP_LAST_F0_MODE       3'h4
`define IOP_FIRST_SINGLE_MODE  3'h6

// Bus responses
`define IOP_RESP_OKAY          2'h0
`define IOP_RESP_DECERR        2'h3

`endif

// ---- shared/port_io_pkg.sv ----
// Types shared by the five-pin port design files.
// Assumes port_io_map.svh on the include path.
`include "port_io_map.svh"
`default_nettype none

package port_io_pkg;
    typedef logic [`IOP_PIN_COUNT-1:0]  pin_vec_type;
    typedef logic [`IOP_MODE_WIDTH-1:0] op_mode_type;
    typedef enum logic {
        pin_role_expanded,
        pin_role_single_chip
    } pin_role_type;
endpackage : port_io_pkg

`default_nettype wire

// ---- verilog/pin_sync.sv ----
// Two-stage synchroniser for levels that arrive from pins.
// Assumes one clock; the first stage feeds only the second.
`include "port_io_map.svh"
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock
    input  wire logic             aclk,
    // Levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage_one;

    // No reset: the chain flushes within two edges of any reset
    always_ff @(posedge aclk) begin
        stage_one <= async_in;
        sync_out  <= stage_one;
    end
endmodule : pin_sync

`default_nettype wire

// ---- verilog/pin_mux.sv ----
// Per-pin function selection: generic output, chip select, refresh strobe.
// Assumes direction and latch from flip-flops on the same clock.
`include "port_io_map.svh"
`default_nettype none

module pin_mux (
    // Register state
    input  wire logic [`IOP_PIN_COUNT-1:0] dir,
    input  wire logic [`IOP_PIN_COUNT-1:0] latch,
    input  wire port_io_pkg::pin_role_type role,
    input  wire logic                      hw_standby,
    // Alternate sources
    input  wire logic [`IOP_CS_COUNT-1:0]  chip_select_n,
    input  wire logic                      refresh_strobe_n,
    input  wire logic                      refresh_output_enable,
    // Pins
    output logic      [`IOP_PIN_COUNT-1:0] pin_out,
    output logic      [`IOP_PIN_COUNT-1:0] pin_oe
);
    wire expanded = (role == port_io_pkg::pin_role_expanded);
    wire refresh_on = expanded & refresh_output_enable;

    genvar i;
    generate
        for (i = 1; i < `IOP_PIN_COUNT; i++) begin : g_cs_pin
            // Pin 4 carries select 0, pin 1 select 3
            assign pin_out[i] = expanded ? chip_select_n[`IOP_PIN_COUNT-1-i]
                                         : latch[i];
            assign pin_oe[i]  = dir[i] & ~hw_standby;
        end
    endgenerate

    assign pin_out[0] = refresh_on ? refresh_strobe_n : latch[0];
    assign pin_oe[0]  = (refresh_on | dir[0]) & ~hw_standby;
endmodule : pin_mux

`default_nettype wire

// ---- verilog/io_port_top.sv ----
// Five-pin bidirectional port with AXI4-Lite register access.
// Assumes pins arrive asynchronously; select and refresh inputs share aclk.
//
// Summary of operation
// - Five bidirectional pins 4..0, each with direction and latch bit.
// - Expanded modes: set direction makes pins 4..1 selects 0..3, pin 0 generic.
// - A cleared direction bit makes its pin an input in every mode, except pin 0 while it drives the refresh strobe.
// - Single-chip modes 6, 7: each pin generic output or input by its bit.
// - Pins 3..0 always feed external interrupt request inputs 3..0.
// - Direction register is write-only; reads return all ones.
// - Reset/hardware standby load direction F0 in modes 1-4, E0 in 5-7.
// - Software standby keeps direction and output state of output pins.
// - Output latch register holds the five pin bits, readable and writable.
// - Data read returns latch for output pins, live level for inputs.
// - Data bits 7..5 reserved: writes ignored, reads return one.
// - Reset/hardware standby load data register E0; software standby keeps it.
// - Expanded modes with refresh enabled: pin 0 drives the refresh strobe.
`include "port_io_map.svh"
`default_nettype none

module io_port_top (
    // Clock and reset
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    // Write address
    input  wire logic [`IOP_ADDR_WIDTH-1:0] awaddr,
    input  wire logic                       awvalid,
    output logic                            awready,
    // Write data
    input  wire logic [31:0]                wdata,
    input  wire logic [3:0]                 wstrb,
    input  wire logic                       wvalid,
    output logic                            wready,
    // Write response
    output logic      [1:0]                 bresp,
    output logic                            bvalid,
    input  wire logic                       bready,
    // Read address
    input  wire logic [`IOP_ADDR_WIDTH-1:0] araddr,
    input  wire logic                       arvalid,
    output logic                            arready,
    // Read data
    output logic      [31:0]                rdata,
    output logic      [1:0]                 rresp,
    output logic                            rvalid,
    input  wire logic                       rready,
    // Chip state
    input  wire logic [`IOP_MODE_WIDTH-1:0] op_mode,
    input  wire logic                       hw_standby_n,
    // Alternate functions
    input  wire logic [`IOP_CS_COUNT-1:0]   chip_select_n,
    input  wire logic                       refresh_strobe_n,
    input  wire logic                       refresh_output_enable,
    output logic      [`IOP_IRQ_COUNT-1:0]  external_interrupt_request_n,
    // Pins
    input  wire logic [`IOP_PIN_COUNT-1:0]  pin_in,
    output logic      [`IOP_PIN_COUNT-1:0]  pin_out,
    output logic      [`IOP_PIN_COUNT-1:0]  pin_oe
);
    localparam int SYNC_WIDTH = `IOP_PIN_COUNT + `IOP_MODE_WIDTH + 1;
    localparam logic [7:0] DATA_RESET = `IOP_DATA_RESET;

    function automatic port_io_pkg::pin_role_type role_of(
        input port_io_pkg::op_mode_type mode
    );
        role_of = (mode >= `IOP_FIRST_SINGLE_MODE) ? port_io_pkg::pin_role_single_chip
                                                   : port_io_pkg::pin_role_expanded;
    endfunction : role_of

    function automatic logic [7:0] dir_reset_of(input port_io_pkg::op_mode_type mode);
        dir_reset_of = (mode <= `IOP_LAST_F0_MODE) ? `IOP_DIR_RESET_LOW
                                                   : `IOP_DIR_RESET_HIGH;
    endfunction : dir_reset_of

    function automatic logic hits(input logic [`IOP_ADDR_WIDTH-1:0] addr,
                                  input logic [15:0]                index);
        hits = (addr[`IOP_INDEX_MSB:`IOP_INDEX_LSB] == index);
    endfunction : hits

    // Synchronised pin, mode and standby levels
    logic [SYNC_WIDTH-1:0]      sync_bus;
    port_io_pkg::pin_vec_type   pin_level;
    port_io_pkg::op_mode_type   mode_level;
    logic                       hw_standby_level_n;

    pin_sync #(
        .WIDTH (SYNC_WIDTH)
    ) u_pin_sync (
        .aclk     (aclk),
        .async_in ({hw_standby_n, op_mode, pin_in}),
        .sync_out (sync_bus)
    );

    assign pin_level          = sync_bus[`IOP_PIN_COUNT-1:0];
    assign mode_level         = sync_bus[SYNC_WIDTH-2:`IOP_PIN_COUNT];
    assign hw_standby_level_n = sync_bus[SYNC_WIDTH-1];

    wire hw_standby = ~hw_standby_level_n;
    wire init_req   = ~aresetn | hw_standby;
    port_io_pkg::pin_role_type role;
    assign role = role_of(mode_level);

    // Register state; only pin bits are stored
    port_io_pkg::pin_vec_type dir;
    port_io_pkg::pin_vec_type latch;

    // Write path: address and data taken together
    wire wr_fire     = awvalid & wvalid & ~bvalid;
    wire wr_dir_hit  = hits(awaddr, `IOP_DIR_INDEX);
    wire wr_data_hit = hits(awaddr, `IOP_DATA_INDEX);
    wire wr_lane0    = wstrb[0];
    wire wr_dir      = wr_fire & wr_dir_hit & wr_lane0 & ~hw_standby;
    wire wr_data     = wr_fire & wr_data_hit & wr_lane0 & ~hw_standby;

    assign awready = wr_fire;
    assign wready  = wr_fire;

    logic [7:0] dir_reset;
    assign dir_reset = dir_reset_of(mode_level);

    // Software standby issues no writes, so both registers simply hold
    always_ff @(posedge aclk) begin
        if (init_req) begin
            dir <= dir_reset[`IOP_PIN_COUNT-1:0];
        end else if (wr_dir) begin
            dir <= wdata[`IOP_PIN_COUNT-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (init_req) begin
            // Reserved bits are not stored, so only the pin bits load
            latch <= DATA_RESET[`IOP_PIN_COUNT-1:0];
        end else if (wr_data) begin
            latch <= wdata[`IOP_PIN_COUNT-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= `IOP_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp  <= (wr_dir_hit | wr_data_hit) ? `IOP_RESP_OKAY : `IOP_RESP_DECERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Read path
    wire rd_fire     = arvalid & ~rvalid;
    wire rd_dir_hit  = hits(araddr, `IOP_DIR_INDEX);
    wire rd_data_hit = hits(araddr, `IOP_DATA_INDEX);

    assign arready = ~rvalid;

    port_io_pkg::pin_vec_type port_view;
    assign port_view = (dir & latch) | (~dir & pin_level);

    wire [7:0] data_word = {`IOP_RESERVED_ONES, port_view};
    wire [7:0] read_byte = rd_dir_hit  ? `IOP_DIR_READ_VALUE :
                           rd_data_hit ? data_word : 8'h00;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h00000000;
            rresp  <= `IOP_RESP_OKAY;
        end else if (rd_fire) begin
            rvalid <= 1'b1;
            rdata  <= {24'h000000, read_byte};
            rresp  <= (rd_dir_hit | rd_data_hit) ? `IOP_RESP_OKAY : `IOP_RESP_DECERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // Pin drive
    pin_mux u_pin_mux (
        .dir                   (dir),
        .latch                 (latch),
        .role                  (role),
        .hw_standby            (hw_standby),
        .chip_select_n         (chip_select_n),
        .refresh_strobe_n      (refresh_strobe_n),
        .refresh_output_enable (refresh_output_enable),
        .pin_out               (pin_out),
        .pin_oe                (pin_oe)
    );

    // Interrupt requests see the pin whatever its direction
    assign external_interrupt_request_n = pin_level[`IOP_IRQ_COUNT-1:0];

    // Checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    wire single_chip = (role == port_io_pkg::pin_role_single_chip);

    a_dir_reads_ones: assert property (
        rd_fire && rd_dir_hit |=> rvalid && rdata == 32'h000000FF)
        else $error("direction read did not return all ones");

    a_data_read_mix: assert property (
        rd_fire && rd_data_hit |=> rdata[4:0] == $past(port_view))
        else $error("data read did not merge latch and pin levels");

    a_reserved_ones: assert property (
        rd_fire && rd_data_hit |=> rdata[7:5] == 3'b111 && rdata[31:8] == 24'h0)
        else $error("reserved data bits not read as one");

    a_latch_update: assert property (
        wr_data |=> latch == $past(wdata[4:0]) ##1 $stable(latch) || wr_data)
        else $error("latch did not take written value");

    a_generic_drive: assert property (
        single_chip && dir[0] && !hw_standby |-> pin_oe[0] && pin_out[0] == latch[0])
        else $error("single-chip output pin does not follow latch");

    a_input_released: assert property (
        pin_oe[4:1] == (dir[4:1] & {4{~hw_standby}}))
        else $error("pin driven while direction bit cleared");

    a_select_route: assert property (
        !single_chip && dir[4] |-> pin_out[4] == chip_select_n[0] && pin_out[1]
            == chip_select_n[3])
        else $error("chip select not routed to its pin");

    a_refresh_pin: assert property (
        !single_chip && refresh_output_enable && !hw_standby
            |-> pin_oe[0] && pin_out[0] == refresh_strobe_n)
        else $error("refresh strobe not on pin 0");

    a_irq_follow: assert property (
        external_interrupt_request_n == $past(pin_in[3:0], 2))
        else $error("interrupt request does not follow pin after two edges");

    a_init_values: assert property (
        $fell(hw_standby) |-> dir == dir_reset[4:0] && latch == 5'h00)
        else $error("standby exit left wrong register values");

    a_resp_hold: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped before accept");

    a_dir_write: assert property (
        wr_dir |=> dir == $past(wdata[4:0]))
        else $error("direction register did not take written value");

    a_dir_keep: assert property (
        !wr_dir && !init_req |=> $stable(dir))
        else $error("direction register changed without a write");

    a_latch_keep: assert property (
        !wr_data && !init_req |=> $stable(latch))
        else $error("output latch changed without a write");

    a_standby_release: assert property (
        hw_standby |-> pin_oe == 5'h00)
        else $error("pin driven during hardware standby");

    c_write_data: cover property (wr_data ##1 bvalid && bready);
    c_dir_write: cover property (wr_dir ##1 bvalid);
    c_read_dir: cover property (rd_fire && rd_dir_hit ##1 rvalid);
    c_refresh_out: cover property (!single_chip && refresh_output_enable && pin_oe[0]);
    c_single_chip_out: cover property (single_chip && |pin_oe);
endmodule : io_port_top

`default_nettype wire

// ---- sim/pin_board_model.sv ----
// Board around the five port pins: resolves each pin from both drivers.
// Assumes pin_oe high while the port drives; the board drives every pin.
`default_nettype none

module pin_board_model (
    // Port side
    input  wire logic [4:0] pin_out,
    input  wire logic [4:0] pin_oe,
    // Board side
    input  wire logic [4:0] board_level,
    output logic      [4:0] pin_level
);
    timeunit 1ns;
    timeprecision 1ns;

    // Board drivers are weak: an enabled port driver always wins
    assign pin_level = (pin_out & pin_oe) | (board_level & ~pin_oe);
endmodule : pin_board_model

`default_nettype wire

// ---- sim/five_bit_io_port_with_alt_functions_tb.sv ----
// Self-checking bench for the five-pin port with register access.
// Assumes port_io_map.svh on the include path and the board model beside it.
`include "port_io_map.svh"
`default_nettype none

module five_bit_io_port_with_alt_functions_tb;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [17:0] DIR_A  = {`IOP_DIR_INDEX, 2'h0};
    localparam logic [17:0] DATA_A = {`IOP_DATA_INDEX, 2'h0};

    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [17:0] awaddr = 18'h0;
    logic [17:0] araddr = 18'h0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic [2:0]  op_mode = 3'h1;
    logic        hw_standby_n = 1'b1;
    logic [3:0]  chip_select_n = 4'hF;
    logic        refresh_strobe_n = 1'b1;
    logic        refresh_output_enable = 1'b0;
    logic [4:0]  board = 5'h00;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [3:0]  irq_n;
    logic [4:0]  pin_in, pin_out, pin_oe;
    logic [1:0]  resp;
    logic [31:0] rd;
    int          error_cnt = 0;
    int          checks_done = 0;
    int          cycles = 0;

    always #20 aclk = ~aclk;

    io_port_top i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .op_mode(op_mode), .hw_standby_n(hw_standby_n), .chip_select_n(chip_select_n),
        .refresh_strobe_n(refresh_strobe_n), .refresh_output_enable(refresh_output_enable),
        .external_interrupt_request_n(irq_n), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe));

    pin_board_model i_board (.pin_out(pin_out), .pin_oe(pin_oe), .board_level(board),
        .pin_level(pin_in));

    task automatic end_of_test;
        $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    always @(posedge aclk) begin
        cycles <= cycles + 1;
        // Whole run needs well under a thousand cycles
        if (cycles == 5000) begin
            error_cnt++;
            end_of_test();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Ready stays high between transfers so back-to-back calls never toggle it twice
    task automatic axw(input logic [17:0] a, input logic [7:0] d, input bit stall,
                       output logic [1:0] r);
        awaddr  <= a;
        wdata   <= {24'h0, d};
        wstrb   <= 4'hF;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= ~stall;
        do @(posedge aclk); while (awready !== 1'b1);
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        // Stalled response must stand until bready returns
        if (stall) begin
            repeat (2) @(posedge aclk);
            bready <= 1'b1;
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
    endtask : axw

    task automatic axr(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
    endtask : axr

    task automatic restart(input logic [2:0] m);
        aresetn <= 1'b0;
        op_mode <= m;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask : restart

    task automatic t_reset_values;
        restart(3'h1);
        board <= 5'h0A;
        repeat (3) @(posedge aclk);
        chk("oe mode1", pin_oe, 5'h10);
        axr(DIR_A, rd, resp);
        chk("dir read", rd, 32'hFF);
        axr(DATA_A, rd, resp);
        chk("data read", rd, 32'hEA);
        chk("irq", irq_n, 4'hA);
        restart(3'h5);
        chk("oe mode5", pin_oe, 5'h00);
    endtask : t_reset_values

    task automatic t_single_chip;
        restart(3'h7);
        axw(DIR_A, 8'h1F, 1'b0, resp);
        axw(DATA_A, 8'h15, 1'b0, resp);
        chk("out", pin_out, 5'h15);
        chk("oe", pin_oe, 5'h1F);
        axw(DATA_A, 8'h0A, 1'b0, resp);
        axr(DATA_A, rd, resp);
        chk("reserved", rd, 32'hEA);
        repeat (20) @(posedge aclk);
        chk("held", pin_out, 5'h0A);
        axw(DIR_A, 8'h03, 1'b0, resp);
        board <= 5'h14;
        repeat (3) @(posedge aclk);
        chk("oe in", pin_oe, 5'h03);
        axr(DATA_A, rd, resp);
        chk("mixed", rd, 32'hF6);
        chk("irq mix", irq_n, 4'h6);
    endtask : t_single_chip

    task automatic t_expanded;
        restart(3'h1);
        axw(DIR_A, 8'h1F, 1'b0, resp);
        axw(DATA_A, 8'h01, 1'b0, resp);
        chip_select_n <= 4'h6;
        @(posedge aclk);
        chk("selects", pin_out, 5'h0D);
        refresh_output_enable <= 1'b1;
        refresh_strobe_n <= 1'b0;
        axw(DIR_A, 8'h1E, 1'b0, resp);
        chk("refresh", {pin_oe, 3'h0, pin_out}, {5'h1F, 3'h0, 5'h0C});
        refresh_strobe_n <= 1'b1;
        refresh_output_enable <= 1'b0;
        @(posedge aclk);
        chk("refresh off", pin_oe, 5'h1E);
    endtask : t_expanded

    // Pin 0 is an input here, so the latch is judged at pin_out, which still carries it undriven
    task automatic t_unmapped;
        axw(DATA_A + 18'h4, 8'h00, 1'b1, resp);
        chk("bresp", resp, `IOP_RESP_DECERR);
        axr(DATA_A + 18'h4, rd, resp);
        chk("rdata unmapped", rd, 32'h0);
        chk("rresp", resp, `IOP_RESP_DECERR);
        axr(DATA_A, rd, resp);
        chk("kept", rd, 32'hE0);
        chk("kept resp", resp, `IOP_RESP_OKAY);
        chk("kept pin", pin_out, 5'h0D);
    endtask : t_unmapped

    task automatic t_hw_standby;
        restart(3'h1);
        board <= 5'h00;
        axw(DIR_A, 8'h1F, 1'b0, resp);
        axw(DATA_A, 8'h15, 1'b0, resp);
        hw_standby_n <= 1'b0;
        repeat (4) @(posedge aclk);
        chk("standby oe", pin_oe, 5'h00);
        hw_standby_n <= 1'b1;
        repeat (4) @(posedge aclk);
        chk("dir reload", pin_oe, 5'h10);
        axr(DATA_A, rd, resp);
        chk("data reload", rd, 32'hE0);
    endtask : t_hw_standby

    initial begin
        t_reset_values();
        t_single_chip();
        t_expanded();
        t_unmapped();
        t_hw_standby();
        end_of_test();
    end
endmodule : five_bit_io_port_with_alt_functions_tb

`default_nettype wire
